// file: src/lcfp_fault_policy.sv
// fault response policy for current-limit lock and supply window faults
//
// Local design decisions: the placing of the registers and the plain strobed port.
`timescale 1ns/1ps
module lcfp_fault_policy #(
   parameter int unsigned P_RETRY_CYCLES = lcfp_pkg::RETRY_CYCLES
) (
   input wire logic i_clk,
   input wire logic i_rst,
   input wire logic [lcfp_pkg::ADDR_W-1:0] i_addr,
   input wire logic [31:0] i_wdata,
   input wire logic i_wr,
   input wire logic i_rd,
   input wire logic i_ilimit,
   input wire logic [7:0] i_supply_half_v,
   output logic [31:0] o_rdata,
   output logic o_fault_output_pin_n,
   output logic o_gate_hiz,
   output logic o_recirc,
   output logic [2:0] o_hs_on,
   output logic [2:0] o_ls_on,
   output logic o_irq
);

   // ********************************
   // decode functions
   // ********************************
   function automatic logic [4:0] retry_limit(input logic [2:0] code);
      logic [4:0] r;
      case (code)
         3'h1: r = 5'h02;
         3'h2: r = 5'h03;
         3'h3: r = 5'h05;
         3'h4: r = 5'h07;
         3'h5: r = 5'h0a;
         3'h6: r = 5'h0f;
         3'h7: r = 5'h14;
         default: r = 5'h00;
      endcase
      return r;
   endfunction

   // ********************************
   // thresholds in half volts
   // ********************************
   function automatic logic [7:0] low_thr(input logic [2:0] code);
      logic [7:0] r;
      case (code)
         3'h1: r = 8'h09;
         3'h2: r = 8'h0a;
         3'h3: r = 8'h0b;
         3'h4: r = 8'h0c;
         3'h5: r = 8'h0f;
         3'h6: r = 8'h14;
         3'h7: r = 8'h19;
         default: r = 8'h00;
      endcase
      return r;
   endfunction

   function automatic logic [7:0] high_thr(input logic [2:0] code);
      logic [7:0] r;
      case (code)
         3'h1: r = 8'h28;
         3'h2: r = 8'h2d;
         3'h3: r = 8'h32;
         3'h4: r = 8'h37;
         3'h5: r = 8'h3c;
         3'h6: r = 8'h41;
         3'h7: r = 8'h46;
         default: r = 8'hff;
      endcase
      return r;
   endfunction

   // ********************************
   // bus strobe decode and stage drive
   // ********************************
   function automatic logic bus_hit(input logic strobe, input logic [lcfp_pkg::ADDR_W-1:0] addr,
      input logic [lcfp_pkg::ADDR_W-1:0] target);
      return strobe && addr == target;
   endfunction

   // stage drive of a stored action as {hiz, recirc, hs_on, ls_on}
   function automatic logic [7:0] stage_of(input logic [1:0] act);
      logic [7:0] r;
      case (act)
         2'h0: r = 8'h80;
         2'h1: r = 8'h40;
         2'h2: r = 8'h38;
         2'h3: r = 8'h07;
         default: r = 8'h80;
      endcase
      return r;
   endfunction

   // ********************************
   // state and working signals
   // ********************************
   lcfp_pkg::lcfp_state_s s_reg;
   lcfp_pkg::lcfp_state_s s_next;
   logic [3:0] act_code;
   logic [3:0] deg_code;
   logic [2:0] low_code;
   logic [2:0] high_code;
   logic [4:0] limit;
   logic [lcfp_pkg::ST_W-1:0] clr;
   logic [lcfp_pkg::ST_W-1:0] set;
   logic tick;
   logic detect_on;
   logic lock_raw;
   logic uv_cond;
   logic ov_cond;
   logic uv_hold;
   logic ov_hold;
   logic limit_hit;
   logic wait_done;

   // ********************************
   // retry timing
   // ********************************
   // a zero interval must not wrap the terminal count below zero
   localparam int unsigned WAIT_LAST = (P_RETRY_CYCLES > 0) ? P_RETRY_CYCLES - 1 : 0;

   // ********************************
   // output registers
   // ********************************
   assign o_rdata = s_reg.rdata;
   assign o_fault_output_pin_n = s_reg.fault_n;
   assign o_gate_hiz = s_reg.hiz;
   assign o_recirc = s_reg.recirc;
   assign o_hs_on = s_reg.hs_on;
   assign o_ls_on = s_reg.ls_on;
   assign o_irq = s_reg.irq;

   // ********************************
   // next state
   // ********************************
   always_comb begin
      s_next = s_reg;
      set = '0;
      act_code = s_reg.cfg[lcfp_pkg::LOCK_ACT_LSB +: lcfp_pkg::LOCK_ACT_W];
      deg_code = s_reg.cfg[lcfp_pkg::LOCK_DEG_LSB +: lcfp_pkg::LOCK_DEG_W];
      low_code = s_reg.cfg[lcfp_pkg::LOW_THR_LSB +: lcfp_pkg::THR_W];
      high_code = s_reg.cfg[lcfp_pkg::HIGH_THR_LSB +: lcfp_pkg::THR_W];
      limit = retry_limit(s_reg.cfg[lcfp_pkg::RETRY_LIM_LSB +: lcfp_pkg::THR_W]);
      clr = bus_hit(i_wr, i_addr, lcfp_pkg::CLEAR_ADDR) ? i_wdata[lcfp_pkg::ST_W-1:0] : '0;
      limit_hit = limit != 5'h00 && s_reg.retries >= limit;
      wait_done = s_reg.wait_cnt >= WAIT_LAST;

      // ********************************
      // register writes
      // ********************************
      if (bus_hit(i_wr, i_addr, lcfp_pkg::CFG_ADDR)) begin
         s_next.cfg = i_wdata;
      end
      if (bus_hit(i_wr, i_addr, lcfp_pkg::IRQ_EN_ADDR)) begin
         s_next.ien = i_wdata[lcfp_pkg::ST_W-1:0];
      end

      // ********************************
      // lock deglitch in microsecond steps
      // ********************************
      detect_on = act_code <= lcfp_pkg::ACT_REPORT;
      tick = s_reg.us_div == 5'(lcfp_pkg::US_CYCLES - 1);
      if (!i_ilimit || !detect_on) begin
         s_next.us_div = '0;
         s_next.deg_cnt = '0;
      end else begin
         s_next.us_div = tick ? 5'h00 : s_reg.us_div + 5'h01;
         if (tick && s_reg.deg_cnt != 4'hf) begin
            s_next.deg_cnt = s_reg.deg_cnt + 4'h1;
         end
      end
      lock_raw = i_ilimit && detect_on && (s_reg.deg_cnt >= deg_code);

      // ********************************
      // lock action state machine
      // ********************************
      case (s_reg.lock_st)
         lcfp_pkg::LCFP_IDLE: begin
            if (lock_raw) begin
               set[lcfp_pkg::ST_LOCK] = 1'b1;
               if (act_code <= lcfp_pkg::ACT_LATCH_LAST) begin
                  s_next.lock_st = lcfp_pkg::LCFP_LATCHED;
                  s_next.act = act_code[1:0];
                  set[lcfp_pkg::ST_LATCH] = 1'b1;
               end else if (act_code <= lcfp_pkg::ACT_RETRY_LAST) begin
                  s_next.act = act_code[1:0];
                  if (limit_hit) begin
                     s_next.lock_st = lcfp_pkg::LCFP_LATCHED;
                     set[lcfp_pkg::ST_LATCH] = 1'b1;
                  end else begin
                     s_next.lock_st = lcfp_pkg::LCFP_WAIT;
                     s_next.wait_cnt = '0;
                     set[lcfp_pkg::ST_RETRY] = 1'b1;
                  end
               end
            end
         end
         lcfp_pkg::LCFP_WAIT: begin
            if (wait_done) begin
               s_next.lock_st = lcfp_pkg::LCFP_IDLE;
               if (s_reg.retries != 5'h1f) begin
                  s_next.retries = s_reg.retries + 5'h01;
               end
            end else begin
               s_next.wait_cnt = s_reg.wait_cnt + 32'h1;
            end
         end
         lcfp_pkg::LCFP_LATCHED: begin
            if (clr[lcfp_pkg::ST_LATCH]) begin
               s_next.lock_st = lcfp_pkg::LCFP_IDLE;
            end
         end
         default: begin
            s_next.lock_st = lcfp_pkg::LCFP_IDLE;
         end
      endcase
      if (clr[lcfp_pkg::ST_LATCH]) begin
         s_next.retries = '0;
      end

      // ********************************
      // supply window
      // ********************************
      uv_cond = low_code != 3'h0 && i_supply_half_v < low_thr(low_code);
      ov_cond = high_code != 3'h0 && i_supply_half_v > high_thr(high_code);
      uv_hold = s_reg.uv && low_code != 3'h0 && !s_reg.cfg[lcfp_pkg::LOW_POL_BIT];
      ov_hold = s_reg.ov && high_code != 3'h0 && !s_reg.cfg[lcfp_pkg::HIGH_POL_BIT];
      s_next.uv = uv_cond || (uv_hold && !clr[lcfp_pkg::ST_LOW]);
      s_next.ov = ov_cond || (ov_hold && !clr[lcfp_pkg::ST_HIGH]);
      set[lcfp_pkg::ST_LOW] = uv_cond;
      set[lcfp_pkg::ST_HIGH] = ov_cond;

      // ********************************
      // sticky status, a new event wins over a clear
      // ********************************
      s_next.sts = (s_reg.sts & ~clr) | set;
      s_next.irq = |(s_next.sts & s_next.ien);

      // ********************************
      // output stage
      // ********************************
      s_next.fault_n = 1'b1;
      s_next.hiz = 1'b0;
      s_next.recirc = 1'b0;
      s_next.hs_on = 3'h0;
      s_next.ls_on = 3'h0;
      if (s_next.lock_st != lcfp_pkg::LCFP_IDLE) begin
         s_next.fault_n = 1'b0;
         {s_next.hiz, s_next.recirc, s_next.hs_on, s_next.ls_on} = stage_of(s_next.act);
      end else if (s_next.uv || s_next.ov) begin
         s_next.fault_n = 1'b0;
         s_next.hiz = 1'b1;
      end

      // ********************************
      // read data, valid the cycle after the strobe only
      // ********************************
      s_next.rdata = '0;
      if (i_rd) begin
         case (i_addr)
            lcfp_pkg::CFG_ADDR: s_next.rdata = s_reg.cfg;
            lcfp_pkg::STATUS_ADDR: s_next.rdata = {27'h0, s_reg.sts};
            lcfp_pkg::IRQ_EN_ADDR: s_next.rdata = {27'h0, s_reg.ien};
            lcfp_pkg::STATE_ADDR: begin
               s_next.rdata[1:0] = {s_reg.ov, s_reg.uv};
               s_next.rdata[3:2] = s_reg.lock_st;
               s_next.rdata[8:4] = s_reg.retries;
               s_next.rdata[10:9] = s_reg.act;
            end
            default: s_next.rdata = '0;
         endcase
      end
   end

   // ********************************
   // state register
   // ********************************
   always_ff @(posedge i_clk) begin
      if (i_rst) begin
         s_reg <= '0;
         s_reg.cfg <= lcfp_pkg::CFG_RESET;
         s_reg.fault_n <= 1'b1;
      end else begin
         s_reg <= s_next;
      end
   end

endmodule

// file: src/lcfp_pkg.sv
// shared constants and types of the lock and supply fault policy block
package lcfp_pkg;

   // ********************************
   // register map
   // ********************************
   localparam int ADDR_W = 8;
   localparam logic [7:0] CFG_ADDR = 8'h92;
   localparam logic [7:0] STATUS_ADDR = 8'h94;
   localparam logic [7:0] CLEAR_ADDR = 8'h96;
   localparam logic [7:0] IRQ_EN_ADDR = 8'h98;
   localparam logic [7:0] STATE_ADDR = 8'h9a;
   localparam logic [31:0] CFG_RESET = 32'h0000_0000;

   // ********************************
   // configuration field positions
   // ********************************
   localparam int LOCK_ACT_LSB = 15;
   localparam int LOCK_ACT_W = 4;
   localparam int LOCK_DEG_LSB = 11;
   localparam int LOCK_DEG_W = 4;
   localparam int LOW_THR_LSB = 8;
   localparam int LOW_POL_BIT = 7;
   localparam int HIGH_THR_LSB = 4;
   localparam int HIGH_POL_BIT = 3;
   localparam int RETRY_LIM_LSB = 0;
   localparam int THR_W = 3;

   // ********************************
   // lock action codes
   // ********************************
   localparam logic [3:0] ACT_LATCH_LAST = 4'h3;
   localparam logic [3:0] ACT_RETRY_LAST = 4'h7;
   localparam logic [3:0] ACT_REPORT = 4'h8;

   // ********************************
   // status bits (sticky, shared by clear and enable)
   // ********************************
   localparam int ST_W = 5;
   localparam int ST_LOCK = 0;
   localparam int ST_LATCH = 1;
   localparam int ST_LOW = 2;
   localparam int ST_HIGH = 3;
   localparam int ST_RETRY = 4;

   // ********************************
   // timing
   // ********************************
   localparam int CLK_HZ = 20_000_000;
   localparam int FILTER_STEP_US = 1;
   localparam int US_CYCLES = CLK_HZ / 1_000_000 * FILTER_STEP_US;
   localparam int LOCK_RETRY_MS = 100;
   localparam int RETRY_CYCLES = CLK_HZ / 1000 * LOCK_RETRY_MS;

   // ********************************
   // types
   // ********************************
   typedef enum logic [1:0] {
      LCFP_IDLE = 2'b00,
      LCFP_WAIT = 2'b01,
      LCFP_LATCHED = 2'b10
   } lcfp_lock_e;

   typedef struct packed {
      logic [31:0] cfg;
      logic [ST_W-1:0] sts;
      logic [ST_W-1:0] ien;
      logic [31:0] rdata;
      logic [4:0] us_div;
      logic [3:0] deg_cnt;
      lcfp_lock_e lock_st;
      logic [1:0] act;
      logic [4:0] retries;
      logic [31:0] wait_cnt;
      logic uv;
      logic ov;
      logic fault_n;
      logic hiz;
      logic recirc;
      logic [2:0] hs_on;
      logic [2:0] ls_on;
      logic irq;
   } lcfp_state_s;

endpackage

// file: test/lcfp_fault_policy_sva.sv
// assertion checker for the fault policy block
`timescale 1ns/1ps
module lcfp_fault_policy_sva #(
   parameter int unsigned P_RETRY_CYCLES = 20
) (
   input wire logic i_clk,
   input wire logic i_rst,
   input wire logic [lcfp_pkg::ADDR_W-1:0] i_addr,
   input wire logic [31:0] i_wdata,
   input wire logic i_wr,
   input wire logic i_rd,
   input wire logic i_ilimit,
   input wire logic [7:0] i_supply_half_v,
   input wire logic [31:0] o_rdata,
   input wire logic o_fault_output_pin_n,
   input wire logic o_gate_hiz,
   input wire logic o_recirc,
   input wire logic [2:0] o_hs_on,
   input wire logic [2:0] o_ls_on,
   input wire logic o_irq
);
   // ********************************
   // shadow config and threshold tables
   // ********************************
   logic [31:0] cfg_reg;
   logic [3:0] act;
   logic no_thr;
   logic [7:0] lo_lim [8];
   logic [7:0] hi_lim [8];
   assign lo_lim = '{8'h00, 8'h09, 8'h0a, 8'h0b, 8'h0c, 8'h0f, 8'h14, 8'h19};
   assign hi_lim = '{8'h00, 8'h28, 8'h2d, 8'h32, 8'h37, 8'h3c, 8'h41, 8'h46};
   assign act = cfg_reg[18:15];
   assign no_thr = cfg_reg[10:8] == 3'h0 && cfg_reg[6:4] == 3'h0;
   always_ff @(posedge i_clk) begin
      cfg_reg <= i_rst ? lcfp_pkg::CFG_RESET : ((i_wr && i_addr == lcfp_pkg::CFG_ADDR) ? i_wdata : cfg_reg);
   end
   // consecutive cycles with the fault pin low
   int unsigned low_run;
   always_ff @(posedge i_clk) begin
      low_run <= (i_rst || o_fault_output_pin_n) ? 32'h0 : low_run + 32'h1;
   end
   default clocking @(posedge i_clk); endclocking
   default disable iff (i_rst);
   lock_latch_a: assert property (act <= 4'h3 && cfg_reg[14:11] == 4'h0 && i_ilimit
      |=> !o_fault_output_pin_n) else $error("lock did not assert fault pin");
   hs_brake_a: assert property (o_hs_on != 3'h0 |-> o_hs_on == 3'h7 && o_ls_on == 3'h0)
      else $error("high side brake not all three");
   ls_brake_a: assert property (o_ls_on != 3'h0 |-> o_ls_on == 3'h7 && o_hs_on == 3'h0)
      else $error("low side brake not all three");
   report_only_a: assert property (act == 4'h8 && i_ilimit && o_fault_output_pin_n && no_thr
      |=> o_fault_output_pin_n && o_hs_on == 3'h0 && o_ls_on == 3'h0 && !o_gate_hiz && !o_recirc)
      else $error("report mode acted on stage");
   lock_off_a: assert property (act > 4'h8 && i_ilimit && o_fault_output_pin_n && no_thr
      |=> o_fault_output_pin_n) else $error("disabled lock raised fault");
   low_supply_a: assert property (cfg_reg[10:8] != 3'h0 && i_supply_half_v < lo_lim[cfg_reg[10:8]]
      |=> !o_fault_output_pin_n) else $error("undervoltage not flagged");
   high_supply_a: assert property (cfg_reg[6:4] != 3'h0 && i_supply_half_v > hi_lim[cfg_reg[6:4]]
      |=> !o_fault_output_pin_n) else $error("overvoltage not flagged");
   cfg_read_a: assert property (i_rd && i_addr == lcfp_pkg::CFG_ADDR |=> o_rdata == $past(cfg_reg))
      else $error("config readback wrong");
   retry_start_a: assert property (act >= 4'h4 && act <= 4'h7 && cfg_reg[14:11] == 4'h0 && i_ilimit
      && o_fault_output_pin_n |=> !o_fault_output_pin_n) else $error("retry mode ignored lock");
   retry_release_a: assert property (act >= 4'h4 && act <= 4'h7 && cfg_reg[2:0] == 3'h0 && no_thr
      |-> low_run <= P_RETRY_CYCLES + 1) else $error("unlimited retry held fault too long");
endmodule
bind lcfp_fault_policy lcfp_fault_policy_sva #(.P_RETRY_CYCLES(P_RETRY_CYCLES)) u_sva (.i_clk(i_clk),
   .i_rst(i_rst), .i_addr(i_addr), .i_wdata(i_wdata), .i_wr(i_wr), .i_rd(i_rd), .i_ilimit(i_ilimit),
   .i_supply_half_v(i_supply_half_v), .o_rdata(o_rdata), .o_fault_output_pin_n(o_fault_output_pin_n),
   .o_gate_hiz(o_gate_hiz), .o_recirc(o_recirc), .o_hs_on(o_hs_on), .o_ls_on(o_ls_on), .o_irq(o_irq));

// file: test/tb_top.sv
// self-checking bench for the fault policy block
`timescale 1ns/1ps
module tb_top;
   logic i_clk = 1'b0;
   logic i_rst = 1'b1;
   logic [7:0] i_addr = 8'h00;
   logic [31:0] i_wdata = 32'h0;
   logic i_wr = 1'b0;
   logic i_rd = 1'b0;
   logic i_ilimit = 1'b0;
   logic [7:0] i_supply_half_v = 8'h14;
   logic [31:0] o_rdata;
   logic o_fault_output_pin_n;
   logic o_gate_hiz;
   logic o_recirc;
   logic [2:0] o_hs_on;
   logic [2:0] o_ls_on;
   logic o_irq;
   logic [31:0] rv;
   int mismatches = 0;
   int n_tests = 0;
   lcfp_fault_policy #(.P_RETRY_CYCLES(20)) uut (.i_clk(i_clk), .i_rst(i_rst), .i_addr(i_addr),
      .i_wdata(i_wdata), .i_wr(i_wr), .i_rd(i_rd), .i_ilimit(i_ilimit), .i_supply_half_v(i_supply_half_v),
      .o_rdata(o_rdata), .o_fault_output_pin_n(o_fault_output_pin_n), .o_gate_hiz(o_gate_hiz),
      .o_recirc(o_recirc), .o_hs_on(o_hs_on), .o_ls_on(o_ls_on), .o_irq(o_irq));
   initial begin
      forever #25 i_clk = ~i_clk;
   end
   // ********************************
   // bus, compare and stimulus helpers
   // ********************************
   task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
      n_tests++;
      if (seen !== exp) begin
         mismatches++;
         $display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask
   task automatic cyc(input int n);
      repeat (n) @(posedge i_clk);
      #1;
   endtask
   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      @(posedge i_clk);
      i_addr <= a;
      i_wdata <= d;
      i_wr <= 1'b1;
      @(posedge i_clk);
      i_wr <= 1'b0;
   endtask
   task automatic rd(input logic [7:0] a);
      @(posedge i_clk);
      i_addr <= a;
      i_rd <= 1'b1;
      @(posedge i_clk);
      i_rd <= 1'b0;
      #1;
      rv = o_rdata;
   endtask
   task automatic lim(input logic v, input int n);
      @(posedge i_clk);
      i_ilimit <= v;
      cyc(n);
   endtask
   task automatic sup(input logic [7:0] v, input logic pin);
      @(posedge i_clk);
      i_supply_half_v <= v;
      cyc(3);
      chk(o_fault_output_pin_n, pin);
   endtask
   function automatic logic [31:0] stg();
      return {23'h0, o_fault_output_pin_n, o_gate_hiz, o_recirc, o_hs_on, o_ls_on};
   endfunction
   task automatic t_lock();
      logic [3:0] codes [6] = '{4'h0, 4'h1, 4'h2, 4'h3, 4'h8, 4'h9};
      logic [8:0] exp [6] = '{9'h080, 9'h040, 9'h038, 9'h007, 9'h100, 9'h100};
      for (int k = 0; k < 6; k++) begin
         wr(lcfp_pkg::CFG_ADDR, {13'h0, codes[k], 15'h0});
         lim(1'b1, 3);
         lim(1'b0, 2);
         chk(stg(), {23'h0, exp[k]});
         rd(lcfp_pkg::STATUS_ADDR);
         chk(rv[0], codes[k] != 4'h9);
         wr(lcfp_pkg::CLEAR_ADDR, 32'h1f);
         cyc(2);
         chk(stg(), 32'h100);
      end
   endtask
   task automatic t_deg();
      wr(lcfp_pkg::CFG_ADDR, 32'h0000_0800);
      lim(1'b1, 17);
      lim(1'b0, 3);
      chk(o_fault_output_pin_n, 1'b1);
      lim(1'b1, 24);
      chk(o_fault_output_pin_n, 1'b0);
      lim(1'b0, 1);
      wr(lcfp_pkg::CLEAR_ADDR, 32'h1f);
   endtask
   task automatic t_retry(input logic [2:0] code, input int n, input logic [6:0] exp);
      wr(lcfp_pkg::CFG_ADDR, {29'h0000_4000, code});
      lim(1'b1, n);
      rd(lcfp_pkg::STATE_ADDR);
      chk(rv[8:2], exp);
      lim(1'b0, 30);
      wr(lcfp_pkg::CLEAR_ADDR, 32'h1f);
   endtask
   task automatic t_supply();
      wr(lcfp_pkg::IRQ_EN_ADDR, 32'h04);
      wr(lcfp_pkg::CFG_ADDR, 32'h0000_0100);
      sup(8'h08, 1'b0);
      chk({o_gate_hiz, o_irq}, 2'h3);
      sup(8'h09, 1'b0);
      wr(lcfp_pkg::IRQ_EN_ADDR, 32'h00);
      cyc(2);
      chk(o_irq, 1'b0);
      wr(lcfp_pkg::CLEAR_ADDR, 32'h04);
      cyc(2);
      chk(o_fault_output_pin_n, 1'b1);
      wr(lcfp_pkg::CFG_ADDR, 32'h0000_0180);
      sup(8'h08, 1'b0);
      sup(8'h09, 1'b1);
      wr(lcfp_pkg::CFG_ADDR, 32'h0000_0070);
      sup(8'h47, 1'b0);
      sup(8'h46, 1'b0);
      wr(lcfp_pkg::CLEAR_ADDR, 32'h08);
      cyc(2);
      chk(o_fault_output_pin_n, 1'b1);
      wr(lcfp_pkg::CFG_ADDR, 32'h0000_0078);
      sup(8'h47, 1'b0);
      sup(8'h46, 1'b1);
   endtask
   task automatic conclude();
      $display("mismatches=%0d n_tests=%0d", mismatches, n_tests);
      if (mismatches == 0 && n_tests > 0) begin
         $display("[ PASS ]");
      end else begin
         $display("[ FAIL ]");
      end
      $finish;
   endtask
   initial begin
      repeat (4) @(posedge i_clk);
      i_rst <= 1'b0;
      rd(lcfp_pkg::CFG_ADDR);
      chk(rv, lcfp_pkg::CFG_RESET);
      rd(8'h00);
      chk(rv, 32'h0);
      t_lock();
      t_deg();
      t_retry(3'h1, 200, 7'h0a);
      t_retry(3'h7, 700, 7'h52);
      t_retry(3'h0, 300, 7'h39);
      t_supply();
      conclude();
   end
   initial begin
      #2_000_000;
      mismatches++;
      conclude();
   end
endmodule
